// ---- sdm_core.sv ----
// sdram device core: command decode, four banks, byte masks, self refresh
// assumes the controller keeps the power-up sequence; inputs are pins
`timescale 1ns/10ps
module sdm_core #(
  parameter int ROW_W = 13,
  parameter int COL_W = 9
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic        cke_i,
  input  wire logic        bank_select_low_i,
  input  wire logic        bank_select_high_i,
  input  wire logic [12:0] addr_i,
  input  wire logic        upper_byte_mask_i,
  input  wire logic        lower_byte_mask_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [1:0]  dq_oe_o,
  output logic             self_refresh_o,
  output logic             mode_set_o,
  output logic      [3:0]  retain_banks_o,
  output logic      [1:0]  refresh_period_o
);

  if (ROW_W > 13 || ROW_W < 1 || COL_W > 10 || COL_W < 3)
  begin : g_chk
    $error("sdm_core: ROW_W must be 1..13 and COL_W 3..10");
  end

  localparam int AW = 2 + ROW_W + COL_W;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_SELF = 2'b10
  } sdm_state_t;

  typedef struct packed {
    sdm_pkg::sdm_pins_t         s1;
    sdm_pkg::sdm_pins_t         s2;
    sdm_state_t                 st;
    logic [12:0]                mode;
    logic                       mode_set;
    logic [12:0]                ext;
    logic [3:0]                 row_open;
    logic [3:0][ROW_W-1:0]      row;
    logic                       bst_on;
    logic                       bst_wr;
    logic                       bst_ap;
    logic [1:0]                 bst_bank;
    logic [COL_W-1:0]           bst_start;
    logic [COL_W-1:0]           bst_cnt;
    logic [COL_W:0]             bst_left;
    logic [1:0]                 rd_v;
    logic [1:0][15:0]           rd_d;
    logic [1:0]                 dqm_d1;
    logic [15:0]                dq_out;
    logic [1:0]                 oe;
  } sdm_core_t;

  sdm_core_t q;
  sdm_core_t n;

  // per-byte storage so each lane writes on its own
  logic [7:0] mem_hi [0:(1<<AW)-1];
  logic [7:0] mem_lo [0:(1<<AW)-1];

  logic          we_hi;
  logic          we_lo;
  logic [AW-1:0] waddr;
  logic [15:0]   wdata;

  function automatic logic [COL_W:0] burst_len(input logic [2:0] bl);
    case (bl)
      sdm_pkg::BL_2:  burst_len = (COL_W+1)'(2);
      sdm_pkg::BL_4:  burst_len = (COL_W+1)'(4);
      sdm_pkg::BL_8:  burst_len = (COL_W+1)'(8);
      sdm_pkg::BL_FP: burst_len = {1'b1, {COL_W{1'b0}}};
      default:        burst_len = (COL_W+1)'(1);
    endcase
  endfunction : burst_len

  always_comb
  begin
    sdm_pkg::sdm_pins_t p;
    logic [2:0]         cmd;
    logic               sel;
    logic               run;
    logic               go;
    logic               beat;
    logic [1:0]         b_bank;
    logic [COL_W-1:0]   b_start;
    logic [COL_W-1:0]   b_cnt;
    logic [COL_W:0]     b_left;
    logic               b_wr;
    logic               b_ap;
    logic [COL_W:0]     len;
    logic [COL_W-1:0]   msk;
    logic [COL_W-1:0]   off;
    logic [COL_W-1:0]   col;
    p       = q.s2;
    cmd     = {p.ras_n, p.cas_n, p.we_n};
    sel     = ~p.cs_n;
    run     = (q.st == ST_RUN) & p.cke;
    b_bank  = q.bst_bank;
    b_start = q.bst_start;
    b_cnt   = q.bst_cnt;
    b_wr    = q.bst_wr;
    b_ap    = q.bst_ap;
    b_left  = q.bst_left;
    n       = q;
    n.s1    = '{cs_n: cs_n_i, ras_n: ras_n_i, cas_n: cas_n_i, we_n: we_n_i, cke: cke_i,
                ba: {bank_select_high_i, bank_select_low_i}, addr: addr_i,
                dqm: {upper_byte_mask_i, lower_byte_mask_i}, dq: dq_i};
    n.s2    = q.s1;
    we_hi   = 1'b0;
    we_lo   = 1'b0;
    wdata   = p.dq;

    // read data path: latency set by the mode register
    n.rd_v   = {q.rd_v[0], 1'b0};
    n.rd_d   = {q.rd_d[0], 16'h0000};
    n.dqm_d1 = p.dqm;
    if (q.mode[sdm_pkg::MR_CL_LSB +: 3] == sdm_pkg::CL_3)
    begin
      n.dq_out = q.rd_d[1];
      n.oe     = {2{q.rd_v[1]}} & ~q.dqm_d1;
    end
    else
    begin
      n.dq_out = q.rd_d[0];
      n.oe     = {2{q.rd_v[0]}} & ~q.dqm_d1;
    end

    // a new read or write takes over any running burst
    go = run & sel & ((cmd == sdm_pkg::CMD_RD) | (cmd == sdm_pkg::CMD_WR)) & q.row_open[p.ba];
    len = burst_len(q.mode[sdm_pkg::MR_BL_LSB +: 3]);
    if (go)
    begin
      b_bank  = p.ba;
      b_start = p.addr[COL_W-1:0];
      b_cnt   = '0;
      b_wr    = (cmd == sdm_pkg::CMD_WR);
      b_ap    = p.addr[sdm_pkg::AP_BIT];
      b_left  = (b_wr & q.mode[sdm_pkg::MR_WS_BIT]) ? (COL_W+1)'(1) : len;
    end
    beat = go | (run & q.bst_on);

    // burst wraps inside its block, sequential or interleaved
    msk   = COL_W'(len - (COL_W+1)'(1));
    off   = q.mode[sdm_pkg::MR_BT_BIT] ? (b_start ^ b_cnt) : COL_W'(b_start + b_cnt);
    col   = (b_start & ~msk) | (off & msk);
    waddr = {b_bank, q.row[b_bank], col};

    if (beat)
    begin
      if (b_wr)
      begin
        we_hi = ~p.dqm[1] & ~rst_i;
        we_lo = ~p.dqm[0] & ~rst_i;
      end
      else
      begin
        n.rd_v[0] = 1'b1;
        n.rd_d[0] = {mem_hi[waddr], mem_lo[waddr]};
      end
      n.bst_on    = (b_left > (COL_W+1)'(1));
      n.bst_bank  = b_bank;
      n.bst_start = b_start;
      n.bst_cnt   = COL_W'(b_cnt + COL_W'(1));
      n.bst_left  = b_left - (COL_W+1)'(1);
      n.bst_wr    = b_wr;
      n.bst_ap    = b_ap;
      if (b_left == (COL_W+1)'(1) && b_ap)
      begin
        n.row_open[b_bank] = 1'b0;
      end
    end

    case (q.st)
      ST_RUN:
      begin
        if (!p.cke)
        begin
          // clock suspend holds any burst and ignores commands, the read pipeline still shifts; refresh with cke low enters self refresh
          if (sel && cmd == sdm_pkg::CMD_REF)
          begin
            n.st     = ST_SELF;
            n.bst_on = 1'b0;
          end
        end
        else if (sel)
        begin
          case (cmd)
            sdm_pkg::CMD_ACT:
            begin
              n.row_open[p.ba] = 1'b1;
              n.row[p.ba]      = p.addr[ROW_W-1:0];
            end
            sdm_pkg::CMD_PRE:
            begin
              n.row_open = p.addr[sdm_pkg::AP_BIT] ? 4'h0 : (n.row_open & ~(4'h1 << p.ba));
              n.bst_on   = 1'b0;
            end
            sdm_pkg::CMD_MRS:
            begin
              if (p.ba == sdm_pkg::BA_MODE)
              begin
                n.mode     = p.addr;
                n.mode_set = 1'b1;
              end
              else if (p.ba == sdm_pkg::BA_EXT)
              begin
                n.ext = p.addr;
              end
            end
            sdm_pkg::CMD_BST: n.bst_on = 1'b0;
            default:          n.bst_on = n.bst_on;
          endcase
        end
      end
      ST_SELF:
      begin
        n.st = p.cke ? ST_RUN : ST_SELF;
      end
      default: n.st = ST_RUN;
    endcase

    if (rst_i)
    begin
      n          = '0;
      n.s1       = sdm_pkg::PINS_IDLE;
      n.s2       = sdm_pkg::PINS_IDLE;
      n.st       = ST_RUN;
      n.mode     = sdm_pkg::MODE_RST;
      n.ext      = sdm_pkg::EXT_RST;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    q <= n;
  end

  always_ff @(posedge mclk_i)
  begin
    if (we_hi)
    begin
      mem_hi[waddr] <= wdata[15:8];
    end
    if (we_lo)
    begin
      mem_lo[waddr] <= wdata[7:0];
    end
  end

  // retained banks during self refresh
  always_comb
  begin
    case (q.ext[sdm_pkg::EXT_PASR_LSB +: 3])
      sdm_pkg::PASR_ALL:  retain_banks_o = sdm_pkg::RET_ALL;
      sdm_pkg::PASR_HALF: retain_banks_o = sdm_pkg::RET_HALF;
      default:            retain_banks_o = sdm_pkg::RET_ONE;
    endcase
  end

  assign refresh_period_o = q.ext[sdm_pkg::EXT_TCSR_LSB +: 2];
  assign dq_o             = q.dq_out;
  assign dq_oe_o          = q.oe;
  assign self_refresh_o   = (q.st == ST_SELF);
  assign mode_set_o       = q.mode_set;

endmodule : sdm_core

// ---- sdm_pkg.sv ----
// shared constants and types for the low-power sdram device core
// assumes one controller driving commands on the system clock
package sdm_pkg;

  // pin sample of everything the controller drives
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [1:0]  dqm;
    logic [15:0] dq;
  } sdm_pins_t;

  // {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT  = 2'h2;

  // mode register fields, and the auto-precharge address bit
  localparam int MR_BL_LSB  = 0;
  localparam int MR_BT_BIT  = 3;
  localparam int MR_CL_LSB  = 4;
  localparam int MR_WS_BIT  = 9;
  localparam int AP_BIT     = 10;
  localparam logic [2:0] BL_2  = 3'h1;
  localparam logic [2:0] BL_4  = 3'h2;
  localparam logic [2:0] BL_8  = 3'h3;
  localparam logic [2:0] BL_FP = 3'h7;
  localparam logic [2:0] CL_3  = 3'h3;

  // extended mode register fields
  localparam int EXT_PASR_LSB = 0;
  localparam int EXT_TCSR_LSB = 3;
  localparam logic [2:0] PASR_ALL  = 3'h0;
  localparam logic [2:0] PASR_HALF = 3'h1;
  localparam logic [3:0] RET_ALL   = 4'hf;
  localparam logic [3:0] RET_HALF  = 4'h3;
  localparam logic [3:0] RET_ONE   = 4'h1;

  // reset values
  localparam logic [12:0] MODE_RST = 13'h0000;
  localparam logic [12:0] EXT_RST  = 13'h0000;
  localparam sdm_pins_t   PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                        cke: 1'b1, ba: 2'h0, addr: 13'h0000, dqm: 2'h3,
                                        dq: 16'h0000};

endpackage : sdm_pkg

// ---- sdm_core_checker.sv ----
// pin-level checker for sdm_core: read byte masks, mode and ext register
// assumes cl2 reads; mask pin sampled 4 edges before its beat shows
`timescale 1ns/10ps
module sdm_core_checker (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        cs_n_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic        cke_i,
  input wire logic        bank_select_low_i,
  input wire logic        bank_select_high_i,
  input wire logic [12:0] addr_i,
  input wire logic        upper_byte_mask_i,
  input wire logic        lower_byte_mask_i,
  input wire logic [1:0]  dq_oe_o,
  input wire logic        mode_set_o,
  input wire logic [3:0]  retain_banks_o,
  input wire logic [1:0]  refresh_period_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic mrs;
  logic ext;
  assign mrs = !cs_n_i && cke_i && !ras_n_i && !cas_n_i && !we_n_i && !bank_select_low_i;
  assign ext = mrs && bank_select_high_i;
  chk_upper_read_mask: assert property (dq_oe_o[1] |-> !$past(upper_byte_mask_i, 4))
    else $error("upper lane driven while masked");
  chk_lower_read_mask: assert property (dq_oe_o[0] |-> !$past(lower_byte_mask_i, 4))
    else $error("lower lane driven while masked");
  chk_mode_set_seen: assert property (mrs && !bank_select_high_i |-> ##[2:4] mode_set_o)
    else $error("mode set not flagged");
  chk_mode_set_holds: assert property (mode_set_o |=> mode_set_o)
    else $error("mode set flag dropped");
  chk_retain_half: assert property (ext && addr_i[2:0] == 3'h1 |-> ##[2:4] retain_banks_o == 4'h3)
    else $error("half retention not decoded");
  chk_retain_all: assert property (ext && addr_i[2:0] == 3'h0 |-> ##[2:4] retain_banks_o == 4'hf)
    else $error("full retention not decoded");
  chk_period_two: assert property (ext && addr_i[4:3] == 2'h2 |-> ##[2:4] refresh_period_o == 2'h2)
    else $error("refresh period not decoded");
endmodule : sdm_core_checker

bind sdm_core sdm_core_checker chk (.mclk_i, .rst_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .cke_i,
  .bank_select_low_i, .bank_select_high_i, .addr_i, .upper_byte_mask_i, .lower_byte_mask_i,
  .dq_oe_o, .mode_set_o, .retain_banks_o, .refresh_period_o);

// ---- sdm_ctrl_model.sv ----
// controller stand-in: power-up sequence and single commands on the pins
// assumes the core samples all pins on the rising edge of mclk_i
`timescale 1ns/10ps
module sdm_ctrl_model #(
  parameter int PAUSE_CYC = 50
) (
  input  wire logic         mclk_i,
  output sdm_pkg::sdm_pins_t pins_o
);
  sdm_pkg::sdm_pins_t p_q = sdm_pkg::PINS_IDLE;
  assign pins_o = p_q;

  task automatic cmd(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    p_q.cs_n <= 1'b0;
    {p_q.ras_n, p_q.cas_n, p_q.we_n} <= c;
    p_q.ba <= ba;
    p_q.addr <= a;
    p_q.dq <= d;
    @(posedge mclk_i);
    p_q.cs_n <= 1'b1;
    p_q.dq <= ~d; // released data never keeps its value
  endtask : cmd

  task automatic set_mask(input logic [1:0] m);
    @(posedge mclk_i);
    p_q.dqm <= m;
  endtask : set_mask

  task automatic set_cke(input logic v);
    @(posedge mclk_i);
    p_q.cke <= v;
  endtask : set_cke

  // accesses only after this returns
  task automatic init();
    repeat (PAUSE_CYC) @(posedge mclk_i);
    cmd(sdm_pkg::CMD_PRE, 2'h0, 13'h0400, 16'h0000);
    repeat (8) cmd(sdm_pkg::CMD_REF, 2'h0, 13'h0000, 16'h0000);
    cmd(sdm_pkg::CMD_MRS, sdm_pkg::BA_MODE, 13'h0020, 16'h0000);
  endtask : init
endmodule : sdm_ctrl_model

// ---- sdram_init_and_byte_mask_test.sv ----
// self-checking bench for sdm_core: init, write masks, read masks, ext register
// assumes a small array and cl2, burst of one, set by the controller model
`timescale 1ns/10ps
module sdram_init_and_byte_mask_test;
  logic               mclk_i = 1'b0;
  logic               rst_i  = 1'b1;
  sdm_pkg::sdm_pins_t pin;
  logic [15:0]        dq_o;
  logic [1:0]         dq_oe_o;
  logic               self_refresh_o;
  logic               mode_set_o;
  logic [3:0]         retain_banks_o;
  logic [1:0]         refresh_period_o;
  int                 num_errors = 0;
  int                 checks_done = 0;

  sdm_ctrl_model ctl (.mclk_i, .pins_o(pin));
  sdm_core #(.ROW_W(2), .COL_W(3)) DUT (.mclk_i, .rst_i, .cs_n_i(pin.cs_n), .ras_n_i(pin.ras_n),
    .cas_n_i(pin.cas_n), .we_n_i(pin.we_n), .cke_i(pin.cke), .bank_select_low_i(pin.ba[0]),
    .bank_select_high_i(pin.ba[1]), .addr_i(pin.addr), .upper_byte_mask_i(pin.dqm[1]),
    .lower_byte_mask_i(pin.dqm[0]), .dq_i(pin.dq), .dq_o, .dq_oe_o, .self_refresh_o,
    .mode_set_o, .retain_banks_o, .refresh_period_o);

  initial
  begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [1:0] ba, input logic [15:0] d, input logic [1:0] m);
    ctl.set_mask(m);
    ctl.cmd(sdm_pkg::CMD_WR, ba, 13'h0001, d);
  endtask : wr

  task automatic rd(input logic [1:0] ba, input logic [1:0] m, input logic [15:0] exp);
    ctl.set_mask(m);
    ctl.cmd(sdm_pkg::CMD_RD, ba, 13'h0001, 16'h0000);
    ctl.set_mask(~m);
    repeat (2) @(posedge mclk_i);
    #1;
    check("read lanes", {14'h0, dq_oe_o}, {14'h0, ~m});
    check("read data", dq_o & {{8{~m[1]}}, {8{~m[0]}}}, exp);
  endtask : rd

  task automatic test_init();
    int n;
    check("mode flag", {15'h0, mode_set_o}, 16'h0000);
    check("retention", {12'h0, retain_banks_o}, 16'h000f);
    ctl.init();
    n = 0;
    while (mode_set_o !== 1'b1 && n < 8)
    begin
      @(posedge mclk_i);
      n++;
    end
    check("mode flag", {15'h0, mode_set_o}, 16'h0001);
    if (mode_set_o !== 1'b1)
      print_verdict();
  endtask : test_init

  task automatic test_masks();
    ctl.cmd(sdm_pkg::CMD_ACT, 2'h1, 13'h0000, 16'h0000);
    ctl.cmd(sdm_pkg::CMD_ACT, 2'h2, 13'h0000, 16'h0000);
    wr(2'h1, 16'h5566, 2'h0);
    wr(2'h2, 16'h7788, 2'h0);
    wr(2'h1, 16'habcd, 2'h2);
    wr(2'h2, 16'h99ef, 2'h1);
    rd(2'h1, 2'h0, 16'h55cd);
    rd(2'h2, 2'h0, 16'h9988);
    rd(2'h1, 2'h2, 16'h00cd);
    rd(2'h2, 2'h1, 16'h9900);
  endtask : test_masks

  task automatic test_ext();
    logic [12:0] a [3] = '{13'h0011, 13'h0002, 13'h0018};
    logic [3:0]  r [3] = '{4'h3, 4'h1, 4'hf};
    for (int i = 0; i < 3; i++)
    begin
      ctl.cmd(sdm_pkg::CMD_MRS, sdm_pkg::BA_EXT, a[i], 16'h0000);
      repeat (4) @(posedge mclk_i);
      check("retention", {12'h0, retain_banks_o}, {12'h0, r[i]});
      check("period", {14'h0, refresh_period_o}, {14'h0, a[i][4:3]});
    end
  endtask : test_ext

  task automatic test_self();
    ctl.set_cke(1'b0);
    ctl.cmd(sdm_pkg::CMD_REF, 2'h0, 13'h0000, 16'h0000);
    repeat (3) @(posedge mclk_i);
    #1;
    check("self refresh", {15'h0, self_refresh_o}, 16'h0001);
    ctl.set_cke(1'b1);
    repeat (4) @(posedge mclk_i);
    #1;
    check("self refresh", {15'h0, self_refresh_o}, 16'h0000);
  endtask : test_self

  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    test_init();
    test_masks();
    test_ext();
    test_self();
    print_verdict();
  end
endmodule : sdram_init_and_byte_mask_test
